// ===== hdl/mcc_cfg.svh
`ifndef MCC_CFG_SVH
`define MCC_CFG_SVH
// ----------------------------------------
// clock and timing
// ----------------------------------------
`define MCC_CLK_MHZ 250
`define MCC_BIT_NS 4000
`define MCC_BIT_CYC ((`MCC_BIT_NS * `MCC_CLK_MHZ) / 1000)
`define MCC_RESTART_US 1000
`define MCC_RESTART_CYC (`MCC_RESTART_US * `MCC_CLK_MHZ)
`define MCC_IREF_US 100
`define MCC_IREF_CYC (`MCC_IREF_US * `MCC_CLK_MHZ)
// ----------------------------------------
// phase: one step is 22.5 degrees, 16 steps per cycle
// ----------------------------------------
`define MCC_ADDR_PHASE_STEPS 2
// ----------------------------------------
// strap, share rail and trim
// ----------------------------------------
`define MCC_STRAP_CODES 12
`define MCC_MAX_MEMBERS 8
`define MCC_DROOP_SHIFT 8
// ----------------------------------------
// event bus frame: start, 22 payload bits, guard
// ----------------------------------------
`define MCC_FRAME_BITS 23
`define MCC_MSG_SEQ_UP 3'h1
`define MCC_MSG_SEQ_DN 3'h2
`define MCC_MSG_FAULT 3'h3
`define MCC_MSG_LOST 3'h4
`define MCC_MSG_IREF 3'h5
// ----------------------------------------
// register offsets and reset values
// ----------------------------------------
`define MCC_REG_CTRL 4'h0
`define MCC_REG_PHASE 4'h1
`define MCC_REG_LINK 4'h2
`define MCC_REG_SHARE 4'h3
`define MCC_REG_VNOM 4'h4
`define MCC_REG_DROOP 4'h5
`define MCC_REG_STATUS 4'h6
`define MCC_REG_VTGT 4'h7
`define MCC_REG_IREF 4'h8
`define MCC_CTRL_RST 16'h0018
`define MCC_SHARE_RST 16'h0000
`define MCC_LINK_RST 16'h0000
`define MCC_VNOM_RST 16'h0000
`define MCC_DROOP_RST 16'h0000
`endif

// ===== hdl/mcc_pkg.sv
package mcc_pkg;
	typedef enum logic [1:0] {SYNC_IN, SYNC_AUTO, SYNC_OUT, SYNC_RSVD} mcc_sync_t;
	typedef enum logic [1:0] {ROLE_NONE, ROLE_FIRST, ROLE_LAST, ROLE_MIDDLE} mcc_role_t;
	typedef enum {S_OFF, S_WAIT_ON, S_RUN, S_WAIT_OFF, S_STOP, S_FAULT} mcc_seq_state_t;
	typedef enum {B_IDLE, B_FRAME} mcc_bus_state_t;
	typedef struct packed {
		logic [9:0] rsvd;
		logic peer_restart;
		logic peer_shutdown;
		logic fault_shutdown;
		logic fault_bcast;
		logic phase_from_reg;
		logic cmd_seq;
	} mcc_ctrl_t;
	typedef struct packed {
		logic has_succ;
		logic [6:0] succ;
		logic has_pred;
		logic [6:0] pred;
	} mcc_link_t;
	typedef struct packed {
		logic [8:0] rsvd;
		logic [2:0] last_pos;
		logic [2:0] pos;
		logic en;
	} mcc_share_t;
	typedef struct packed {
		logic [2:0] kind;
		logic [6:0] src;
		logic [11:0] data;
	} mcc_frame_t;
endpackage

// ===== hdl/mcc_coord.sv
// What this block does
// - address-derived phase is address times 45 degrees, wrapping per cycle.
// - software may write phase 0..337.5 degrees in 22.5 degree steps.
// - strap sets sync pin direction so the group shares one clock.
// - autonomous sequencing uses bus events; never offered on a share rail.
// - autonomous sequencing forces the address-derived phase.
// - turn-on runs lowest address first, then ascending.
// - turn-off runs highest address first, then descending.
// - strap code picks one of twelve sync and role combinations.
// - command sequencing takes predecessor and successor from registers.
// - shared enable rising starts turn-on, falling starts turn-off.
// - own fault with shutdown and broadcast enabled sends a fault event when not on a share rail.
// - peer fault shuts down if configured; restart rejoins sequence later.
// - lowest member position on the rail acts as reference.
// - reference broadcasts its current; members trim to balance.
// - member target is nominal plus droop times current difference, over 256.
// - after reset the device is standalone, no sharing.
// - survivors keep regulating; lowest surviving position becomes reference.
// - rail sends a fault event only when all its devices failed.
// - a rail holds at most eight members.
// - a share rail may join a command sequencing group.
`timescale 1ns/1ps
`default_nettype none
`include "mcc_cfg.svh"
module mcc_coord import mcc_pkg::*; #(
	parameter int MAX_MEMBERS = `MCC_MAX_MEMBERS,
	parameter int RESTART_CYC = `MCC_RESTART_CYC,
	parameter int IREF_CYC = `MCC_IREF_CYC
) (
	// clock, reset, enable
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	// register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	// straps and converter status
	input wire logic [6:0] dev_addr_i,
	input wire logic [3:0] strap_code_i,
	input wire logic grp_en_i,
	input wire logic pgood_i,
	input wire logic fault_i,
	input wire logic [11:0] iout_i,
	// converter control
	output logic run_o,
	output logic [3:0] phase_o,
	output logic [1:0] sync_mode_o,
	output logic share_ref_o,
	output logic [15:0] member_voltage_target_o,
	// open-drain event bus
	input wire logic interdevice_event_bus_i,
	output logic interdevice_event_bus_o,
	output logic interdevice_event_bus_oe_n_o
);
	localparam logic [9:0] BIT_LAST = 10'(`MCC_BIT_CYC - 1);
	localparam logic [9:0] BIT_MID = 10'(`MCC_BIT_CYC / 2);

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	if (MAX_MEMBERS < 1 || MAX_MEMBERS > 8 || RESTART_CYC < 1 || IREF_CYC < 1) begin : g_bad_param
		$error("mcc_coord: unsupported parameter value");
	end

	// ----------------------------------------
	// functions
	// ----------------------------------------
	function automatic logic [3:0] addr_phase(input logic [6:0] a);
		logic [7:0] p;
		p = {1'b0, a} * 8'(`MCC_ADDR_PHASE_STEPS);
		return p[3:0];
	endfunction

	function automatic logic [3:0] lowest_alive(input logic [7:0] failed, input logic [2:0] last);
		logic [3:0] r;
		r = 4'h8;
		for (int i = 7; i >= 0; i--) begin
			if (i <= int'(last) && !failed[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	function automatic logic rail_dead(input logic [7:0] failed, input logic [2:0] last);
		return lowest_alive(failed, last) == 4'h8;
	endfunction

	function automatic logic [15:0] trim_target(input logic [15:0] vnom, input logic [15:0] droop,
		input logic [11:0] iref, input logic [11:0] iown);
		logic signed [12:0] di;
		logic signed [30:0] prod;
		logic signed [31:0] sum;
		di = $signed({1'b0, iref}) - $signed({1'b0, iown});
		prod = di * $signed({1'b0, droop});
		sum = $signed({16'h0000, vnom}) + 32'(prod >>> `MCC_DROOP_SHIFT);
		if (sum < 0) begin
			return 16'h0000;
		end else if (sum > 32'sh0000_ffff) begin
			return 16'hffff;
		end
		return sum[15:0];
	endfunction

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	mcc_ctrl_t ctrl_q;
	mcc_link_t link_q;
	mcc_share_t share_q;
	logic [3:0] phase_reg_q;
	logic [15:0] vnom_q, droop_q, rdata_q;
	logic strap_done_q;
	mcc_role_t role_q;
	mcc_sync_t sync_q;
	logic [6:0] addr_q;
	mcc_seq_state_t seq_q;
	logic run_q, up_sent_q, ref_q;
	logic [3:0] phase_q;
	logic [15:0] vtgt_q;
	logic [11:0] iref_q;
	logic [7:0] failed_q;
	logic [17:0] restart_cnt_q, iref_cnt_q;
	logic [4:0] pend_q;
	mcc_bus_state_t bus_q;
	logic [9:0] bitcnt_q;
	logic [4:0] bidx_q;
	logic txing_q, drive_q;
	logic [2:0] txk_q;
	mcc_frame_t txfr_q;
	logic [21:0] rxsh_q;
	logic rx_vld_q;

	// ----------------------------------------
	// mode decode
	// ----------------------------------------
	logic share_on, auto_seq, has_pred, has_succ, own_alive, is_ref;
	logic [6:0] pred_addr, succ_addr;
	mcc_frame_t rxf;
	logic rx_peer, up_from_pred, dn_from_succ, peer_fault;
	logic own_fault, lost_evt, fault_evt, up_evt, dn_evt, iref_evt;
	logic [7:0] failed_own;
	logic [4:0] set_v, clr_v;
	logic [2:0] pick;
	logic tx_bit;

	assign share_on = share_q.en;
	assign auto_seq = !ctrl_q.cmd_seq && role_q != ROLE_NONE && !share_on;
	// command mode takes its neighbours from the link register, rail or not
	assign has_pred = ctrl_q.cmd_seq ? link_q.has_pred : auto_seq && role_q != ROLE_FIRST;
	assign has_succ = ctrl_q.cmd_seq ? link_q.has_succ : auto_seq && role_q != ROLE_LAST;
	// neighbours are address +/- 1 because the chain has no gaps
	assign pred_addr = ctrl_q.cmd_seq ? link_q.pred : addr_q - 7'h01;
	assign succ_addr = ctrl_q.cmd_seq ? link_q.succ : addr_q + 7'h01;
	assign own_alive = !failed_q[share_q.pos];
	assign is_ref = share_on && own_alive
		&& lowest_alive(failed_q, share_q.last_pos) == {1'b0, share_q.pos};

	// received frame decode; our own frames also appear on the wire
	assign rxf = mcc_frame_t'(rxsh_q);
	assign rx_peer = rx_vld_q && rxf.src != addr_q;
	assign up_from_pred = rx_peer && rxf.kind == `MCC_MSG_SEQ_UP && has_pred && rxf.src == pred_addr;
	assign dn_from_succ = rx_peer && rxf.kind == `MCC_MSG_SEQ_DN && has_succ && rxf.src == succ_addr;
	assign peer_fault = rx_peer && rxf.kind == `MCC_MSG_FAULT && ctrl_q.peer_shutdown;

	// ----------------------------------------
	// event sources for the transmitter
	// ----------------------------------------
	assign own_fault = ce_i && fault_i && ctrl_q.fault_shutdown && seq_q != S_FAULT;
	assign failed_own = failed_q | (8'h01 << share_q.pos);
	assign lost_evt = own_fault && share_on;
	// a rail only reports itself once nobody on it is left
	assign fault_evt = own_fault && ctrl_q.fault_bcast
		&& (!share_on || rail_dead(failed_own, share_q.last_pos));
	assign up_evt = ce_i && seq_q == S_RUN && pgood_i && !up_sent_q;
	assign dn_evt = ce_i && seq_q == S_STOP && !pgood_i;
	assign iref_evt = ce_i && ref_q && run_q && iref_cnt_q == 18'(IREF_CYC - 1);
	assign set_v = {iref_evt, dn_evt, up_evt, lost_evt, fault_evt};
	assign clr_v = (ce_i && bus_q == B_FRAME && bitcnt_q == BIT_LAST && bidx_q == 5'(`MCC_FRAME_BITS)
		&& txing_q) ? 5'(5'h01 << txk_q) : 5'h00;
	assign pick = pend_q[0] ? 3'd0 : pend_q[1] ? 3'd1 : pend_q[2] ? 3'd2 : pend_q[3] ? 3'd3 : 3'd4;

	// ----------------------------------------
	// registers written by software
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			ctrl_q <= mcc_ctrl_t'(`MCC_CTRL_RST);
			link_q <= mcc_link_t'(`MCC_LINK_RST);
			share_q <= mcc_share_t'(`MCC_SHARE_RST);
			phase_reg_q <= 4'h0;
			vnom_q <= `MCC_VNOM_RST;
			droop_q <= `MCC_DROOP_RST;
		end else if (ce_i && reg_wr_i) begin
			case (reg_addr_i)
				`MCC_REG_CTRL: ctrl_q <= mcc_ctrl_t'({10'h000, reg_wdata_i[5:0]});
				`MCC_REG_PHASE: phase_reg_q <= reg_wdata_i[3:0];
				`MCC_REG_LINK: link_q <= mcc_link_t'(reg_wdata_i);
				`MCC_REG_SHARE: share_q <= mcc_share_t'({9'h000, reg_wdata_i[6:0]});
				`MCC_REG_VNOM: vnom_q <= reg_wdata_i;
				`MCC_REG_DROOP: droop_q <= reg_wdata_i;
				default: ;
			endcase
		end
	end

	// read data stand for one cycle only
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			rdata_q <= 16'h0000;
		end else if (ce_i) begin
			rdata_q <= 16'h0000;
			if (reg_rd_i) begin
				case (reg_addr_i)
					`MCC_REG_CTRL: rdata_q <= ctrl_q;
					`MCC_REG_PHASE: rdata_q <= {12'h000, phase_reg_q};
					`MCC_REG_LINK: rdata_q <= link_q;
					`MCC_REG_SHARE: rdata_q <= share_q;
					`MCC_REG_VNOM: rdata_q <= vnom_q;
					`MCC_REG_DROOP: rdata_q <= droop_q;
					`MCC_REG_STATUS: rdata_q <= {failed_q, 1'b0, role_q, ref_q, run_q, 3'(seq_q)};
					`MCC_REG_VTGT: rdata_q <= vtgt_q;
					`MCC_REG_IREF: rdata_q <= {4'h0, iref_q};
					default: rdata_q <= 16'h0000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// strap capture, taken once after reset release
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			strap_done_q <= 1'b0;
			role_q <= ROLE_NONE;
			sync_q <= SYNC_IN;
			addr_q <= 7'h00;
		end else if (ce_i && !strap_done_q) begin
			strap_done_q <= 1'b1;
			addr_q <= dev_addr_i;
			// out-of-range codes fall back to input sync, no sequencing
			if (int'(strap_code_i) < `MCC_STRAP_CODES) begin
				role_q <= mcc_role_t'(2'(strap_code_i / 4'd3));
				sync_q <= mcc_sync_t'(2'(strap_code_i % 4'd3));
			end
		end
	end

	// ----------------------------------------
	// sequencing state machine
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			seq_q <= S_OFF;
			up_sent_q <= 1'b0;
			restart_cnt_q <= 18'h0_0000;
		end else if (ce_i && strap_done_q) begin
			if (own_fault || (peer_fault && seq_q != S_FAULT)) begin
				seq_q <= S_FAULT;
				restart_cnt_q <= 18'h0_0000;
			end else begin
				case (seq_q)
					S_OFF: begin
						up_sent_q <= 1'b0;
						if (grp_en_i) begin
							seq_q <= has_pred ? S_WAIT_ON : S_RUN;
						end
					end
					S_WAIT_ON: begin
						if (!grp_en_i) begin
							seq_q <= S_OFF;
						end else if (up_from_pred) begin
							seq_q <= S_RUN;
						end
					end
					S_RUN: begin
						if (up_evt) begin
							up_sent_q <= 1'b1;
						end
						if (!grp_en_i) begin
							seq_q <= has_succ ? S_WAIT_OFF : S_STOP;
						end
					end
					S_WAIT_OFF: begin
						if (grp_en_i) begin
							seq_q <= S_RUN;
						end else if (dn_from_succ) begin
							seq_q <= S_STOP;
						end
					end
					S_STOP: begin
						if (!pgood_i) begin
							seq_q <= S_OFF;
						end
					end
					S_FAULT: begin
						// restart goes through S_OFF so the device waits its turn again
						if (restart_cnt_q != 18'(RESTART_CYC - 1)) begin
							restart_cnt_q <= restart_cnt_q + 18'h0_0001;
						end
						if (!grp_en_i || (ctrl_q.peer_restart && restart_cnt_q == 18'(RESTART_CYC - 1))) begin
							seq_q <= S_OFF;
						end
					end
					default: seq_q <= S_OFF;
				endcase
			end
		end
	end

	// converter drive and phase follow the state one cycle later
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			run_q <= 1'b0;
			phase_q <= 4'h0;
		end else if (ce_i) begin
			run_q <= seq_q == S_RUN || seq_q == S_WAIT_OFF;
			phase_q <= (auto_seq || !ctrl_q.phase_from_reg) ? addr_phase(addr_q) : phase_reg_q;
		end
	end

	// ----------------------------------------
	// current sharing
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			failed_q <= 8'h00;
		end else if (ce_i) begin
			// a new failure beats the clear when both land together
			failed_q <= (grp_en_i ? failed_q : 8'h00)
				| (lost_evt ? failed_own : 8'h00)
				| ((rx_vld_q && rxf.kind == `MCC_MSG_LOST) ? 8'(8'h01 << rxf.data[2:0]) : 8'h00);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			ref_q <= 1'b0;
			iref_q <= 12'h000;
			vtgt_q <= 16'h0000;
			iref_cnt_q <= 18'h0_0000;
		end else if (ce_i) begin
			ref_q <= is_ref;
			if (rx_peer && rxf.kind == `MCC_MSG_IREF) begin
				iref_q <= rxf.data;
			end
			iref_cnt_q <= (!ref_q || iref_evt) ? 18'h0_0000 : iref_cnt_q + 18'h0_0001;
			// the reference holds nominal; members chase its current
			vtgt_q <= (share_on && !ref_q) ? trim_target(vnom_q, droop_q, iref_q, iout_i) : vnom_q;
		end
	end

	// ----------------------------------------
	// transmit requests; a set in the clearing cycle survives
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			pend_q <= 5'h00;
		end else begin
			pend_q <= (pend_q & ~clr_v) | set_v;
		end
	end

	// ----------------------------------------
	// event bus engine: start bit, 22 bits msb first, guard bit
	// ----------------------------------------
	assign tx_bit = bidx_q < 5'd22 ? txfr_q[5'd21 - bidx_q] : 1'b1;

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			bus_q <= B_IDLE;
			bitcnt_q <= 10'h000;
			bidx_q <= 5'h00;
			txing_q <= 1'b0;
			drive_q <= 1'b0;
			txk_q <= 3'h0;
			txfr_q <= '0;
			rxsh_q <= 22'h00_0000;
			rx_vld_q <= 1'b0;
		end else if (ce_i) begin
			rx_vld_q <= 1'b0;
			case (bus_q)
				B_IDLE: begin
					bitcnt_q <= 10'h000;
					bidx_q <= 5'h00;
					if (!interdevice_event_bus_i) begin
						bus_q <= B_FRAME;
						bitcnt_q <= 10'h001;
					end else if (pend_q != 5'h00 && strap_done_q) begin
						bus_q <= B_FRAME;
						txing_q <= 1'b1;
						drive_q <= 1'b1;
						txk_q <= pick;
						txfr_q.src <= addr_q;
						case (pick)
							3'd0: txfr_q.kind <= `MCC_MSG_FAULT;
							3'd1: txfr_q.kind <= `MCC_MSG_LOST;
							3'd2: txfr_q.kind <= `MCC_MSG_SEQ_UP;
							3'd3: txfr_q.kind <= `MCC_MSG_SEQ_DN;
							default: txfr_q.kind <= `MCC_MSG_IREF;
						endcase
						txfr_q.data <= pick == 3'd1 ? {9'h000, share_q.pos} : pick == 3'd4 ? iout_i : 12'h000;
					end
				end
				B_FRAME: begin
					bitcnt_q <= bitcnt_q + 10'h001;
					if (bitcnt_q == BIT_MID && bidx_q != 5'h00 && bidx_q < 5'(`MCC_FRAME_BITS)) begin
						rxsh_q <= {rxsh_q[20:0], interdevice_event_bus_i};
						// released a one but the wire is low: someone else wins
						if (txing_q && !drive_q && !interdevice_event_bus_i) begin
							txing_q <= 1'b0;
						end
					end
					if (bitcnt_q == BIT_LAST) begin
						bitcnt_q <= 10'h000;
						bidx_q <= bidx_q + 5'h01;
						drive_q <= txing_q && bidx_q < 5'd22 && !tx_bit;
						if (bidx_q == 5'(`MCC_FRAME_BITS)) begin
							bus_q <= B_IDLE;
							rx_vld_q <= 1'b1;
							txing_q <= 1'b0;
							drive_q <= 1'b0;
						end
					end
					if (bitcnt_q == BIT_MID && bidx_q == 5'h00) begin
						drive_q <= drive_q;
					end
				end
				default: bus_q <= B_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// outputs from flops, except the bus data output, which is tied low
	// ----------------------------------------
	assign reg_rdata_o = rdata_q;
	assign run_o = run_q;
	assign phase_o = phase_q;
	assign sync_mode_o = sync_q;
	assign share_ref_o = ref_q;
	assign member_voltage_target_o = vtgt_q;
	assign interdevice_event_bus_o = 1'b0;
	assign interdevice_event_bus_oe_n_o = !drive_q;
endmodule
`default_nettype wire

// ===== verification/mcc_coord_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcc_cfg.svh"
module mcc_coord_chk (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// register port
	input wire logic ce_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_rdata_o,
	// converter side
	input wire logic [6:0] dev_addr_i,
	input wire logic grp_en_i,
	input wire logic fault_i,
	input wire logic run_o,
	input wire logic [3:0] phase_o,
	input wire logic share_ref_o,
	// event bus
	input wire logic interdevice_event_bus_i,
	input wire logic interdevice_event_bus_oe_n_o
);
	logic [15:0] ctrl_q;
	logic [3:0] phase_q;
	logic [3:0] share_q;
	int low_cnt_q;
	// ----------------------------------------
	// helper state
	// ----------------------------------------
	// shadow of the setup words, so the properties know the mode
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			ctrl_q <= `MCC_CTRL_RST;
			phase_q <= 4'h0;
			share_q <= 4'h0;
		end else if (ce_i && reg_wr_i) begin
			if (reg_addr_i == `MCC_REG_CTRL) ctrl_q <= reg_wdata_i;
			if (reg_addr_i == `MCC_REG_PHASE) phase_q <= reg_wdata_i[3:0];
			if (reg_addr_i == `MCC_REG_SHARE) share_q <= reg_wdata_i[3:0];
		end
	end
	// length of our current low run; a bit cut short shows as a remainder
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || interdevice_event_bus_oe_n_o) low_cnt_q <= 0;
		else low_cnt_q <= low_cnt_q + 1;
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	AST_RDATA_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
		else $error("read data not zero outside read");
	// four cycles: address capture and the phase flop both follow reset release
	AST_PHASE_ADDR: assert property (!ctrl_q[1] [*4] |-> phase_o == {dev_addr_i[2:0], 1'b0})
		else $error("phase not taken from address");
	AST_PHASE_REG: assert property ((ctrl_q[1:0] == 2'b11 && $stable(phase_q)) [*3] |-> phase_o == phase_q)
		else $error("phase not taken from register");
	AST_RUN_NEEDS_EN: assert property ($rose(run_o) |-> grp_en_i || $past(grp_en_i))
		else $error("run rose without group enable");
	AST_FAULT_STOP: assert property (fault_i && ctrl_q[3] && run_o |-> ##[1:4] !run_o)
		else $error("no shutdown on fault");
	AST_FAULT_FRAME: assert property ($rose(fault_i) && ctrl_q[3:2] == 2'b11 && !share_q[0] && run_o
		&& interdevice_event_bus_i |-> ##[1:16] !interdevice_event_bus_oe_n_o)
		else $error("no fault frame started");
	AST_BIT_WHOLE: assert property ($rose(interdevice_event_bus_oe_n_o) |-> low_cnt_q % `MCC_BIT_CYC == 0)
		else $error("low bit not held a whole bit time");
	AST_REF_LOW_POS: assert property ((share_q[0] && share_q[3:1] == 3'h0) [*3] |-> share_ref_o)
		else $error("lowest position is not reference");
	AST_STANDALONE: assert property (!share_q[0] [*3] |-> !share_ref_o)
		else $error("reference without sharing");
	// main scenarios reached
	COV_FRAME: cover property ($fell(interdevice_event_bus_oe_n_o));
	COV_RUN: cover property ($rose(run_o));
	COV_REF: cover property ($rose(share_ref_o));
endmodule
bind mcc_coord mcc_coord_chk u_chk (
	.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.dev_addr_i(dev_addr_i), .grp_en_i(grp_en_i), .fault_i(fault_i), .run_o(run_o), .phase_o(phase_o),
	.share_ref_o(share_ref_o), .interdevice_event_bus_i(interdevice_event_bus_i),
	.interdevice_event_bus_oe_n_o(interdevice_event_bus_oe_n_o)
);
`default_nettype wire

// ===== verification/mcc_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcc_cfg.svh"
module mcc_peer_model (
	// clock
	input wire logic core_clk_i,
	// shared wire
	input wire logic bus_i,
	output logic bus_oe_n_o
);
	logic tx_busy = 1'b0;
	logic [21:0] rx_frame = '0;
	int rx_cnt = 0;
	initial bus_oe_n_o = 1'b1;
	// send one whole frame; caller keeps the wire idle first, no arbitration here
	task automatic send(input logic [2:0] kind, input logic [6:0] src, input logic [11:0] data);
		logic [22:0] bits;
		bits = {1'b0, kind, src, data};
		tx_busy = 1'b1;
		for (int i = 22; i >= 0; i--) begin
			bus_oe_n_o <= bits[i];
			repeat (`MCC_BIT_CYC) @(posedge core_clk_i);
		end
		bus_oe_n_o <= 1'b1;
		repeat (`MCC_BIT_CYC) @(posedge core_clk_i);
		tx_busy = 1'b0;
	endtask
	// receiver samples mid-bit, MSB first, skips our own frames
	always begin
		@(posedge core_clk_i);
		if (bus_i === 1'b0 && !tx_busy) begin
			repeat (`MCC_BIT_CYC / 2) @(posedge core_clk_i);
			for (int i = 0; i < 22; i++) begin
				repeat (`MCC_BIT_CYC) @(posedge core_clk_i);
				rx_frame = {rx_frame[20:0], bus_i};
			end
			rx_cnt++;
			repeat (`MCC_BIT_CYC) @(posedge core_clk_i);
		end
	end
endmodule
`default_nettype wire

// ===== verification/test_mcc_coord.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcc_cfg.svh"
module test_mcc_coord;
	logic clk, rst, ce, wr, rd, grp_en, pgood, fault, run, share_ref, dev_oe_n, peer_oe_n, bus_lvl, bus_o;
	logic [3:0] addr, strap, phase;
	logic [15:0] wdata, rdata, vtgt;
	logic [6:0] dev_addr;
	logic [11:0] iout;
	logic [1:0] sync;
	int n_errors = 0;
	int cmp_count = 0;
	// wired-and line with pull-up
	assign bus_lvl = dev_oe_n & peer_oe_n;
	// ----------------------------------------
	// design and far side
	// ----------------------------------------
	mcc_coord #(.RESTART_CYC(50), .IREF_CYC(40)) DUT (
		.core_clk_i(clk), .sys_rst_i(rst), .ce_i(ce), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .dev_addr_i(dev_addr), .strap_code_i(strap),
		.grp_en_i(grp_en), .pgood_i(pgood), .fault_i(fault), .iout_i(iout), .run_o(run), .phase_o(phase),
		.sync_mode_o(sync), .share_ref_o(share_ref), .member_voltage_target_o(vtgt),
		.interdevice_event_bus_i(bus_lvl), .interdevice_event_bus_o(bus_o), .interdevice_event_bus_oe_n_o(dev_oe_n));
	mcc_peer_model peer (.core_clk_i(clk), .bus_i(bus_lvl), .bus_oe_n_o(peer_oe_n));
	// clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	// data stands only in the cycle after the strobe
	task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
		@(posedge clk);
	endtask
	task automatic do_reset(input logic [3:0] code);
		strap <= code;
		rst <= 1'b1;
		cyc(5);
		rst <= 1'b0;
		cyc(3);
	endtask
	task automatic wait_run(input logic v, input int n);
		for (int i = 0; i < n && run !== v; i++) @(posedge clk);
	endtask
	task automatic stop_test;
		if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset_vals;
		logic [15:0] d;
		do_reset(4'h0);
		reg_rd(`MCC_REG_CTRL, d);
		chk("ctrl", `MCC_CTRL_RST, d);
		reg_rd(`MCC_REG_SHARE, d);
		chk("share", `MCC_SHARE_RST, d);
		reg_rd(4'hF, d);
		chk("unmapped", 16'h0000, d);
		chk("ref", 16'h0000, {15'h0, share_ref});
		chk("oe_n", 16'h0001, {15'h0, dev_oe_n});
		chk("bus_o", 16'h0000, {15'h0, bus_o});
	endtask
	task automatic t_strap;
		logic [15:0] d;
		for (int c = 0; c < `MCC_STRAP_CODES; c++) begin
			do_reset(c[3:0]);
			chk("sync", 16'(c % 3), {14'h0, sync});
			reg_rd(`MCC_REG_STATUS, d);
			chk("role", 16'(c / 3), {14'h0, d[6:5]});
		end
	endtask
	// address 0x21 wraps to two steps of 22.5 degrees
	task automatic t_phase;
		do_reset(4'h3);
		chk("phase addr", 16'h0002, {12'h0, phase});
		reg_wr(`MCC_REG_PHASE, 16'h000F);
		reg_wr(`MCC_REG_CTRL, 16'h001A);
		cyc(3);
		chk("phase forced", 16'h0002, {12'h0, phase});
		reg_wr(`MCC_REG_CTRL, 16'h001B);
		cyc(3);
		chk("phase reg", 16'h000F, {12'h0, phase});
	endtask
	// middle device waits for its neighbours both ways
	task automatic t_seq;
		int n;
		do_reset(4'h9);
		grp_en <= 1'b1;
		cyc(200);
		chk("run pre", 16'h0000, {15'h0, run});
		peer.send(`MCC_MSG_SEQ_UP, 7'h20, 12'h000);
		wait_run(1'b1, 100);
		chk("run up", 16'h0001, {15'h0, run});
		n = peer.rx_cnt;
		pgood <= 1'b1;
		for (int i = 0; i < 26000 && peer.rx_cnt == n; i++) @(posedge clk);
		chk("up frame", {6'h0, `MCC_MSG_SEQ_UP, 7'h21}, {6'h0, peer.rx_frame[21:12]});
		grp_en <= 1'b0;
		// our up frame still owns the wire for its last bit and guard
		cyc(2000);
		chk("run hold", 16'h0001, {15'h0, run});
		peer.send(`MCC_MSG_SEQ_DN, 7'h22, 12'h000);
		wait_run(1'b0, 100);
		chk("run down", 16'h0000, {15'h0, run});
		pgood <= 1'b0;
	endtask
	task automatic t_fault;
		logic [3:0] v;
		do_reset(4'h0);
		reg_wr(`MCC_REG_CTRL, 16'h001D);
		grp_en <= 1'b1;
		wait_run(1'b1, 50);
		chk("run cmd", 16'h0001, {15'h0, run});
		fault <= 1'b1;
		for (int i = 0; i < 50 && dev_oe_n !== 1'b0; i++) @(posedge clk);
		cyc(2);
		chk("run fault", 16'h0000, {15'h0, run});
		v = 4'h0;
		for (int i = 0; i < 4; i++) begin
			cyc(i == 0 ? 498 : `MCC_BIT_CYC);
			v = {v[2:0], bus_lvl};
		end
		chk("fault head", {13'h0, `MCC_MSG_FAULT}, {12'h0, v});
		fault <= 1'b0;
		grp_en <= 1'b0;
	endtask
	// member at position 2 of four, then position 0
	task automatic t_share;
		do_reset(4'h0);
		iout <= 12'h100;
		reg_wr(`MCC_REG_VNOM, 16'h1234);
		reg_wr(`MCC_REG_DROOP, 16'h0010);
		reg_wr(`MCC_REG_SHARE, 16'h0035);
		cyc(5);
		chk("member ref", 16'h0000, {15'h0, share_ref});
		chk("target", 16'h1224, vtgt);
		reg_wr(`MCC_REG_SHARE, 16'h0031);
		cyc(5);
		chk("ref elect", 16'h0001, {15'h0, share_ref});
	endtask
	// main sequence
	initial begin
		{rst, ce, wr, rd, grp_en, pgood, fault} <= 7'b1100000;
		{addr, strap, wdata, iout} <= '0;
		dev_addr <= 7'h21;
		t_reset_vals;
		t_strap;
		t_phase;
		t_seq;
		t_fault;
		t_share;
		stop_test;
	end
	// watchdog sized above the three frames of the sequencing test
	initial begin
		cyc(95000);
		n_errors++;
		stop_test;
	end
endmodule
`default_nettype wire
